// ### logic/sar_top.sv
// serial audio receive buffer: receiver, pair buffer, channel fifos and registers
//
// Overview of operation
// [RULE_01] control bit master set drives bit clock and word select; clear means inputs.
// [RULE_02] in slave mode the source drives the bit clock; data sampled on it.
// [RULE_03] master word select divides bit clock by twice the word bits, 50% duty.
// [RULE_04] left and right of one pair enter their fifos in the same cycle.
// [RULE_05] not-empty means one or more pairs, half-full two or more, full four.
// [RULE_06] request raised by any active condition whose mask bit is zero.
// [RULE_07] combined port returns 16-bit left and right, pops one from each fifo.
// [RULE_08] wide ports return the whole sample, up to 24 bits, of the oldest entry.
// [RULE_09] paired ports pack top 16 bits of the two oldest samples of a channel.
// [RULE_10] halfword ports return top 16 bits of the oldest sample of a channel.
// [RULE_11] not-empty stays one while any sample remains after reads.
// [RULE_12] overrun set when a sample arrives at a four-deep fifo; status write clears.
// [RULE_13] underrun set when a read asks more than the fifo holds; status write clears.
// [RULE_14] data port reads pop what they return; unused upper bits read zero.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sar_map.svh"
module sar_top
	import sar_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic BCK_IN,
	input wire logic WS_IN,
	input wire logic SD_IN,
	output logic BCK_OUT,
	output logic BCK_OE,
	output logic WS_OUT,
	output logic WS_OE,
	output logic IRQ
);
	import sar_pkg::*;

	sar_ctrl_t ctrl_q;
	logic [9:0] mask_q, stat;
	logic [31:0] rdata_d;
	logic rx_v, buf_in_rdy, buf_v, take, lost;
	sar_pair_t rx_pair, buf_out;
	sar_pair_t bq_q [2];
	logic bwp_q, brp_q;
	logic [1:0] bcnt_q;
	logic [23:0] mem_q [2][4];
	logic [1:0] wp_q [2];
	logic [1:0] rp_q [2];
	logic [2:0] cnt_q [2];
	logic [23:0] hd [2];
	logic [23:0] nx [2];
	logic [1:0] req [2];
	logic [1:0] pop [2];
	logic [1:0] ovr_q, und_q, ovr_set, und_set;
	logic st_clr;

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// how many entries a read at address a asks from channel ch (0 left, 1 right)
	function automatic logic [1:0] pop_req(input logic [7:0] a, input logic ch);
		logic [1:0] n;
		n = 2'h0;
		case (a)
			`SAR_OFF_L16, `SAR_OFF_L24: n = ch ? 2'h0 : 2'h1;
			`SAR_OFF_R16, `SAR_OFF_R24: n = ch ? 2'h1 : 2'h0;
			`SAR_OFF_L32: n = ch ? 2'h0 : 2'h2;
			`SAR_OFF_R32: n = ch ? 2'h2 : 2'h0;
			`SAR_OFF_LR32: n = 2'h1;
			default: n = 2'h0;
		endcase
		return n;
	endfunction

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RESETN)
			ctrl_q <= `SAR_CTRL_RST;
		else if (WR && ADDR == `SAR_OFF_CTRL)
			ctrl_q <= WDATA & `SAR_CTRL_WMASK; // RULE_01
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN)
			mask_q <= `SAR_MASK_RST;
		else if (WR && ADDR == `SAR_OFF_MASK)
			mask_q <= WDATA[9:0];
	end

	assign st_clr = WR && ADDR == `SAR_OFF_STAT;

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	sar_i2s_rx u_rx (
		.clk(MCLK),
		.rst_n(RESETN),
		.master(ctrl_q.master),
		.bits_m1(ctrl_q.bits_m1),
		.half_div(ctrl_q.half_div),
		.bck_pin(BCK_IN),
		.ws_pin(WS_IN),
		.sd_pin(SD_IN),
		.bck_out(BCK_OUT),
		.ws_out(WS_OUT),
		.pair_valid(rx_v),
		.pair(rx_pair)
	);

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			BCK_OE <= 1'b0;
			WS_OE <= 1'b0;
		end else begin
			BCK_OE <= ctrl_q.master; // RULE_01
			WS_OE <= ctrl_q.master; // RULE_01
		end
	end

	// ----------------------------------------
	// two-entry pair buffer
	// ----------------------------------------
	// the fifo side stalls during a register read so a push never meets a pop;
	// the serial side cannot stall, so a full buffer loses the pair as an overrun
	assign buf_in_rdy = bcnt_q != 2'h2;
	assign buf_v = bcnt_q != 2'h0;
	assign buf_out = bq_q[brp_q];
	assign take = buf_v && !RD;
	assign lost = rx_v && !buf_in_rdy;

	always_ff @(posedge MCLK) begin
		if (rx_v && buf_in_rdy)
			bq_q[bwp_q] <= rx_pair;
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			bwp_q <= 1'b0;
			brp_q <= 1'b0;
			bcnt_q <= 2'h0;
		end else begin
			if (rx_v && buf_in_rdy)
				bwp_q <= ~bwp_q;
			if (take)
				brp_q <= ~brp_q;
			bcnt_q <= bcnt_q + {1'b0, rx_v && buf_in_rdy} - {1'b0, take};
		end
	end

	// ----------------------------------------
	// channel fifos
	// ----------------------------------------
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_ch
			logic push;
			logic [23:0] din;
			assign din = ch ? buf_out.right : buf_out.left;
			// both channels take from one buffer entry in one cycle
			assign push = take && cnt_q[ch] != `SAR_DEPTH; // RULE_04
			assign ovr_set[ch] = (take && cnt_q[ch] == `SAR_DEPTH) || lost; // RULE_12
			assign req[ch] = RD ? pop_req(ADDR, 1'(ch)) : 2'h0;
			assign und_set[ch] = {1'b0, req[ch]} > cnt_q[ch]; // RULE_13
			// an underrun pops only what is present
			assign pop[ch] = und_set[ch] ? cnt_q[ch][1:0] : req[ch]; // RULE_14
			assign hd[ch] = (cnt_q[ch] != 3'h0) ? mem_q[ch][rp_q[ch]] : 24'h000000;
			assign nx[ch] = (cnt_q[ch] > 3'h1) ? mem_q[ch][rp_q[ch] + 2'h1] : 24'h000000;

			always_ff @(posedge MCLK) begin
				if (push)
					mem_q[ch][wp_q[ch]] <= din;
			end

			always_ff @(posedge MCLK) begin
				if (!RESETN) begin
					wp_q[ch] <= 2'h0;
					rp_q[ch] <= 2'h0;
					cnt_q[ch] <= 3'h0;
				end else begin
					if (push)
						wp_q[ch] <= wp_q[ch] + 2'h1;
					rp_q[ch] <= rp_q[ch] + pop[ch];
					cnt_q[ch] <= cnt_q[ch] + {2'h0, push} - {1'b0, pop[ch]}; // RULE_14
				end
			end

			// set wins over a status write in the same cycle
			always_ff @(posedge MCLK) begin
				if (!RESETN) begin
					ovr_q[ch] <= 1'b0;
					und_q[ch] <= 1'b0;
				end else begin
					if (ovr_set[ch])
						ovr_q[ch] <= 1'b1; // RULE_12
					else if (st_clr)
						ovr_q[ch] <= 1'b0;
					if (und_set[ch])
						und_q[ch] <= 1'b1; // RULE_13
					else if (st_clr)
						und_q[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// status and interrupt
	// ----------------------------------------
	always_comb begin
		stat = 10'h000;
		stat[`SAR_ST_RUND] = und_q[1];
		stat[`SAR_ST_LUND] = und_q[0];
		stat[`SAR_ST_ROVR] = ovr_q[1];
		stat[`SAR_ST_LOVR] = ovr_q[0];
		stat[`SAR_ST_LFUL] = cnt_q[0] == `SAR_DEPTH; // RULE_05
		stat[`SAR_ST_LHLF] = cnt_q[0] >= `SAR_HALF; // RULE_05
		stat[`SAR_ST_LNMT] = cnt_q[0] != 3'h0; // RULE_05 RULE_11
		stat[`SAR_ST_RFUL] = cnt_q[1] == `SAR_DEPTH; // RULE_05
		stat[`SAR_ST_RHLF] = cnt_q[1] >= `SAR_HALF; // RULE_05
		stat[`SAR_ST_RNMT] = cnt_q[1] != 3'h0; // RULE_05 RULE_11
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN)
			IRQ <= 1'b0;
		else
			IRQ <= |(stat & ~mask_q); // RULE_06
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (ADDR)
			`SAR_OFF_L16: rdata_d = {16'h0000, hd[0][23:8]}; // RULE_10
			`SAR_OFF_R16: rdata_d = {16'h0000, hd[1][23:8]}; // RULE_10
			`SAR_OFF_L24: rdata_d = {8'h00, hd[0]}; // RULE_08
			`SAR_OFF_R24: rdata_d = {8'h00, hd[1]}; // RULE_08
			`SAR_OFF_L32: rdata_d = {nx[0][23:8], hd[0][23:8]}; // RULE_09
			`SAR_OFF_R32: rdata_d = {nx[1][23:8], hd[1][23:8]}; // RULE_09
			`SAR_OFF_LR32: rdata_d = {hd[1][23:8], hd[0][23:8]}; // RULE_07
			`SAR_OFF_STAT: rdata_d = {22'h0, stat};
			`SAR_OFF_MASK: rdata_d = {22'h0, mask_q};
			`SAR_OFF_CTRL: rdata_d = ctrl_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge MCLK) begin
		if (!RESETN)
			RDATA <= 32'h0000_0000;
		else
			RDATA <= RD ? rdata_d : 32'h0000_0000;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	sequence rd_at(logic [7:0] a);
		RD && ADDR == a;
	endsequence

	sequence two_left;
		cnt_q[0] >= 3'h2;
	endsequence

	sequence two_right;
		cnt_q[1] >= 3'h2;
	endsequence

	master_pins_a: assert property (ctrl_q.master |=> BCK_OE && WS_OE) // RULE_01
		else $error("master mode without pin drive");
	slave_pins_a: assert property (!ctrl_q.master |=> !BCK_OE && !WS_OE) // RULE_02
		else $error("slave mode drives a clock pin");
	pair_push_a: assert property (take && cnt_q[0] < 3'h4 && cnt_q[1] < 3'h4 // RULE_04
		|=> cnt_q[0] == $past(cnt_q[0]) + 3'h1 && cnt_q[1] == $past(cnt_q[1]) + 3'h1)
		else $error("pair not pushed together");
	equal_fill_a: assert property (take && cnt_q[0] == cnt_q[1] && cnt_q[0] < 3'h4 // RULE_04
		|=> cnt_q[0] == cnt_q[1])
		else $error("fifo counts drifted apart");
	level_flags_a: assert property (stat[`SAR_ST_LHLF] |-> stat[`SAR_ST_LNMT] // RULE_05
		&& cnt_q[0] > 3'h1 && (stat[`SAR_ST_LFUL] == (cnt_q[0] == 3'h4)))
		else $error("fill flags disagree with count");
	irq_mask_a: assert property (mask_q == 10'h3FF |=> !IRQ) // RULE_06
		else $error("masked condition raised interrupt");
	irq_raise_a: assert property ((stat & ~mask_q) != 10'h000 |=> IRQ) // RULE_06
		else $error("unmasked condition without interrupt");
	combined_rd_a: assert property (rd_at(`SAR_OFF_LR32) // RULE_07
		&& cnt_q[0] != 3'h0 && cnt_q[1] != 3'h0
		|=> RDATA == {$past(hd[1][23:8]), $past(hd[0][23:8])}
		&& cnt_q[0] == $past(cnt_q[0]) - 3'h1 && cnt_q[1] == $past(cnt_q[1]) - 3'h1)
		else $error("combined read wrong");
	wide_rd_a: assert property (rd_at(`SAR_OFF_L24) |=> RDATA == {8'h00, $past(hd[0])}) // RULE_08
		else $error("wide read wrong");
	right_wide_a: assert property (rd_at(`SAR_OFF_R24) // RULE_08
		|=> RDATA == {8'h00, $past(hd[1])})
		else $error("right wide read wrong");
	paired_rd_a: assert property (rd_at(`SAR_OFF_L32) ##0 two_left // RULE_09
		|=> RDATA == {$past(nx[0][23:8]), $past(hd[0][23:8])}
		&& cnt_q[0] == $past(cnt_q[0]) - 3'h2)
		else $error("paired read wrong");
	right_paired_a: assert property (rd_at(`SAR_OFF_R32) ##0 two_right // RULE_09
		|=> RDATA == {$past(nx[1][23:8]), $past(hd[1][23:8])}
		&& cnt_q[1] == $past(cnt_q[1]) - 3'h2)
		else $error("right paired read wrong");
	half_rd_a: assert property (rd_at(`SAR_OFF_R16) // RULE_10 RULE_14
		|=> RDATA == {16'h0000, $past(hd[1][23:8])})
		else $error("halfword read wrong");
	left_half_a: assert property (rd_at(`SAR_OFF_L16) // RULE_10 RULE_14
		|=> RDATA == {16'h0000, $past(hd[0][23:8])})
		else $error("left halfword read wrong");
	rdata_idle_a: assert property (!RD // RULE_14
		|=> RDATA == 32'h0000_0000)
		else $error("read data outside its cycle");
	drain_flag_a: assert property (rd_at(`SAR_OFF_L16) ##0 two_left // RULE_11
		|=> stat[`SAR_ST_LNMT])
		else $error("not-empty dropped with data left");
	right_drain_a: assert property (rd_at(`SAR_OFF_R16) ##0 two_right // RULE_11
		|=> stat[`SAR_ST_RNMT])
		else $error("right not-empty dropped with data left");
	overrun_set_a: assert property (take && cnt_q[1] == 3'h4 // RULE_12
		|=> ovr_q[1] ##1 (ovr_q[1] || $past(st_clr)))
		else $error("overrun not flagged");
	full_hold_a: assert property (take && cnt_q[0] == 3'h4 // RULE_12
		|=> cnt_q[0] == 3'h4 && ovr_q[0])
		else $error("full fifo took a sample");
	overrun_clear_a: assert property (st_clr && !ovr_set[0] // RULE_12
		|=> !ovr_q[0])
		else $error("status write left overrun set");
	underrun_set_a: assert property (rd_at(`SAR_OFF_L32) && cnt_q[0] == 3'h0 // RULE_13
		|=> und_q[0] && cnt_q[0] == 3'h0)
		else $error("underrun not flagged");
	right_under_a: assert property (rd_at(`SAR_OFF_R16) && cnt_q[1] == 3'h0 // RULE_13
		|=> und_q[1] && cnt_q[1] == 3'h0)
		else $error("right underrun not flagged");
	underrun_clear_a: assert property (st_clr && !und_set[1] // RULE_13
		|=> !und_q[1])
		else $error("status write left underrun set");
endmodule // sar_top

// ### logic/sar_map.svh
// register offsets, field positions, reset values and sizes for the serial audio receiver
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
`define SAR_OFF_L16 8'h00
`define SAR_OFF_R16 8'h04
`define SAR_OFF_L24 8'h08
`define SAR_OFF_R24 8'h0C
`define SAR_OFF_STAT 8'h10
`define SAR_OFF_MASK 8'h14
`define SAR_OFF_L32 8'h20
`define SAR_OFF_R32 8'h40
`define SAR_OFF_LR32 8'h60
`define SAR_OFF_CTRL 8'h80
`define SAR_CTRL_RST 32'h0003_1F00
`define SAR_CTRL_WMASK 32'h00FF_1F01
`define SAR_MASK_RST 10'h3FF
`define SAR_ST_RUND 0
`define SAR_ST_LUND 1
`define SAR_ST_ROVR 2
`define SAR_ST_LOVR 3
`define SAR_ST_LFUL 4
`define SAR_ST_LHLF 5
`define SAR_ST_LNMT 6
`define SAR_ST_RFUL 7
`define SAR_ST_RHLF 8
`define SAR_ST_RNMT 9
`define SAR_DEPTH 3'h4
`define SAR_HALF 3'h2
`define SAR_SAMPLE_W 24
`endif

// ### logic/sar_pkg.sv
// types shared by the serial audio receiver files
package sar_pkg;
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} sar_pair_t;
	typedef struct packed {
		logic [7:0] rsv2;
		logic [7:0] half_div;
		logic [2:0] rsv1;
		logic [4:0] bits_m1;
		logic [6:0] rsv0;
		logic master;
	} sar_ctrl_t;
endpackage

// ### logic/sar_i2s_rx.sv
// serial audio receiver: pin sync, master clock generation and deserialiser
`timescale 1ns/1ps
module sar_i2s_rx
	import sar_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic master,
	input wire logic [4:0] bits_m1,
	input wire logic [7:0] half_div,
	input wire logic bck_pin,
	input wire logic ws_pin,
	input wire logic sd_pin,
	output logic bck_out,
	output logic ws_out,
	output logic pair_valid,
	output sar_pkg::sar_pair_t pair
);
	import sar_pkg::*;

	logic bck_s1_q, bck_s2_q, bck_s3_q, ws_s1_q, ws_s2_q, sd_s1_q, sd_s2_q;
	logic [7:0] div_q;
	logic [4:0] bit_q, cnt_q, cnt_nx, sh_amt;
	logic [23:0] sh_q, sh_nx, word;
	logic tick, rise, ws_smp, wsp_q;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{bck_s1_q, bck_s2_q, bck_s3_q} <= 3'h0;
			{ws_s1_q, ws_s2_q, sd_s1_q, sd_s2_q} <= 4'h0;
		end else begin
			bck_s1_q <= bck_pin;
			bck_s2_q <= bck_s1_q;
			bck_s3_q <= bck_s2_q;
			ws_s1_q <= ws_pin;
			ws_s2_q <= ws_s1_q;
			sd_s1_q <= sd_pin;
			sd_s2_q <= sd_s1_q;
		end
	end

	// ----------------------------------------
	// master clock generation
	// ----------------------------------------
	assign tick = master && (div_q == half_div);

	always_ff @(posedge clk) begin
		if (!rst_n || !master) begin
			div_q <= 8'h00;
			bck_out <= 1'b0;
			bit_q <= 5'h00;
			ws_out <= 1'b0;
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			if (tick) begin
				bck_out <= ~bck_out;
				// ws toggles with the falling edge, period 2 x word bits
				if (bck_out) begin // RULE_03
					bit_q <= (bit_q == bits_m1) ? 5'h00 : bit_q + 5'h01;
					if (bit_q == bits_m1)
						ws_out <= ~ws_out;
				end
			end
		end
	end

	// ----------------------------------------
	// deserialiser
	// ----------------------------------------
	// slave samples on the external clock edge, master on its own
	assign rise = master ? (tick && !bck_out) : (bck_s2_q && !bck_s3_q); // RULE_01 RULE_02
	assign ws_smp = master ? ws_out : ws_s2_q;
	assign sh_nx = (cnt_q < 5'h18) ? {sh_q[22:0], sd_s2_q} : sh_q;
	assign cnt_nx = (cnt_q < 5'h18) ? cnt_q + 5'h01 : cnt_q;
	assign sh_amt = 5'h18 - cnt_nx;
	// words longer than 24 bits keep their top 24, shorter ones are left aligned
	assign word = sh_nx << sh_amt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_q <= 24'h000000;
			cnt_q <= 5'h00;
			wsp_q <= 1'b0;
			pair_valid <= 1'b0;
			pair <= '0;
		end else begin
			pair_valid <= 1'b0;
			if (rise) begin
				wsp_q <= ws_smp;
				if (ws_smp != wsp_q) begin
					sh_q <= 24'h000000;
					cnt_q <= 5'h00;
					if (!wsp_q)
						pair.left <= word;
					else begin
						pair.right <= word;
						pair_valid <= 1'b1;
					end
				end else begin
					sh_q <= sh_nx;
					cnt_q <= cnt_nx;
				end
			end
		end
	end

	ws_period_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		master && tick && bck_out && bit_q != bits_m1 |=> $stable(ws_out))
		else $error("word select moved before the word ended");
endmodule // sar_i2s_rx

// ### testbench/sar_i2s_src.sv
// i2s source model driving the slave-mode pins of the receiver
`timescale 1ns/1ps
module sar_i2s_src
	import sar_pkg::*;
(
	output logic bck,
	output logic ws,
	output logic sd
);
	initial begin
		bck = 1'b0;
		ws = 1'b0;
		sd = 1'b0;
	end
	// ----------------------------------------
	// frame sender
	// ----------------------------------------
	// 32-bit words msb first, low byte is filler the receiver drops
	// half period of 14 ns stays above the three-cycle synchroniser minimum
	task automatic send(input sar_pair_t q[$]);
		logic b[$];
		logic c[$];
		logic [31:0] w;
		foreach (q[i]) begin
			for (int h = 0; h < 2; h++) begin
				w = h ? {q[i].right, ~q[i].right[7:0]} : {q[i].left, ~q[i].left[7:0]};
				for (int k = 31; k >= 0; k--) begin
					b.push_back(w[k]);
					c.push_back(h[0]);
				end
			end
		end
		c.push_back(1'b0);
		foreach (b[k]) begin
			bck = 1'b0;
			sd = b[k];
			ws = c[k + 1];
			#14;
			bck = 1'b1;
			#14;
		end
		// clock stands still between bursts; released data line shows the inverse
		bck = 1'b0;
		sd = ~sd;
	endtask
endmodule // sar_i2s_src

// ### testbench/test_i2s_input_receive_buffer.sv
// self-checking bench for the serial audio receive buffer
`timescale 1ns/1ps
`include "sar_map.svh"
module test_i2s_input_receive_buffer;
	import sar_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic bck, ws, sd, bck_out, bck_oe, ws_out, ws_oe, irq, bck_pin, ws_pin;
	int fail_count = 0;
	int num_checks = 0;
	int seed = 32'hB0C03C4A;
	sar_pair_t sent[$];

	always #2 mclk = ~mclk;
	// pin level resolved from both drivers
	assign bck_pin = bck_oe ? bck_out : bck;
	assign ws_pin = ws_oe ? ws_out : ws;

	sar_i2s_src u_src (.bck(bck), .ws(ws), .sd(sd));
	sar_top u_dut (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .BCK_IN(bck_pin), .WS_IN(ws_pin), .SD_IN(sd), .BCK_OUT(bck_out),
		.BCK_OE(bck_oe), .WS_OUT(ws_out), .WS_OE(ws_oe), .IRQ(irq));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd_reg(a, v);
		check(what, v, exp);
	endtask
	function automatic logic [31:0] stat(input int l, input int r, input logic [3:0] err);
		return {22'h0, r >= 1, r >= 2, r >= 4, l >= 1, l >= 2, l >= 4, err};
	endfunction
	// fixed wait covers pin synchronisers plus the push latency
	task automatic push(input int n);
		sar_pair_t q[$];
		sar_pair_t p;
		for (int i = 0; i < n; i++) begin
			p.left = 24'($random(seed));
			p.right = 24'($random(seed));
			q.push_back(p);
			sent.push_back(p);
		end
		// keep pin edges off the sampling edge of the clock
		#1;
		u_src.send(q);
		repeat (12) @(posedge mclk);
	endtask
	task automatic span(input bit sel, output int n);
		logic s;
		s = sel ? ws_out : bck_out;
		n = 0;
		while ((sel ? ws_out : bck_out) === s && n < 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		sar_pair_t p;
		int n;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		#1;
		check("pins idle", {28'h0, bck_oe, ws_oe, irq, rdata[0]}, 32'h0);
		rd_chk("ctrl", `SAR_OFF_CTRL, 32'h0003_1F00);
		rd_chk("mask", `SAR_OFF_MASK, 32'h0000_03FF);
		rd_chk("status", `SAR_OFF_STAT, 32'h0);
		rd_chk("unmapped", 8'hF0, 32'h0);
		$display("test reset done");
		// first frame after reset may be partial, so flush it
		push(1);
		rd_reg(`SAR_OFF_LR32, v);
		wr_reg(`SAR_OFF_STAT, 32'h0);
		sent.delete();
		push(4);
		rd_chk("status full", `SAR_OFF_STAT, stat(4, 4, 4'h0));
		push(1);
		void'(sent.pop_back());
		rd_chk("status over", `SAR_OFF_STAT, stat(4, 4, 4'hC));
		for (int i = 0; i < 10; i++) begin
			wr_reg(`SAR_OFF_MASK, ~(32'h1 << i));
			@(posedge mclk);
			#1;
			check("irq", {31'h0, irq}, {31'h0, i >= 2});
		end
		wr_reg(`SAR_OFF_MASK, 32'h0000_03FF);
		@(posedge mclk);
		#1;
		check("irq masked", {31'h0, irq}, 32'h0);
		wr_reg(`SAR_OFF_STAT, 32'($random(seed)));
		rd_chk("over clear", `SAR_OFF_STAT, stat(4, 4, 4'h0));
		$display("test fill done");
		rd_chk("left wide", `SAR_OFF_L24, {8'h0, sent[0].left});
		rd_chk("status split", `SAR_OFF_STAT, stat(3, 4, 4'h0));
		rd_chk("right wide", `SAR_OFF_R24, {8'h0, sent[0].right});
		rd_chk("left half", `SAR_OFF_L16, {16'h0, sent[1].left[23:8]});
		rd_chk("right half", `SAR_OFF_R16, {16'h0, sent[1].right[23:8]});
		rd_chk("status two", `SAR_OFF_STAT, stat(2, 2, 4'h0));
		rd_chk("left pair", `SAR_OFF_L32, {sent[3].left[23:8], sent[2].left[23:8]});
		rd_chk("right pair", `SAR_OFF_R32, {sent[3].right[23:8], sent[2].right[23:8]});
		rd_chk("status empty", `SAR_OFF_STAT, stat(0, 0, 4'h0));
		rd_chk("right under", `SAR_OFF_R16, 32'h0);
		rd_chk("status rund", `SAR_OFF_STAT, stat(0, 0, 4'h1));
		rd_chk("left under", `SAR_OFF_L32, 32'h0);
		rd_chk("status lund", `SAR_OFF_STAT, stat(0, 0, 4'h3));
		wr_reg(`SAR_OFF_STAT, 32'h0);
		rd_chk("under clear", `SAR_OFF_STAT, stat(0, 0, 4'h0));
		sent.delete();
		$display("test ports done");
		for (int k = 0; k < 8; k++) begin
			n = 1 + ($random(seed) & 3);
			push(n);
			for (int j = 0; j < n; j++) begin
				p = sent.pop_front();
				rd_chk("combined", `SAR_OFF_LR32, {p.right[23:8], p.left[23:8]});
				rd_chk("status", `SAR_OFF_STAT, stat(n - j - 1, n - j - 1, 4'h0));
			end
		end
		$display("test random done");
		// master: half_div 1 gives a four-cycle bit clock, eight bits per word
		wr_reg(`SAR_OFF_CTRL, 32'h0001_0701);
		repeat (4) @(posedge mclk);
		#1;
		check("master oe", {30'h0, bck_oe, ws_oe}, 32'h3);
		span(1'b1, n);
		for (int i = 0; i < 2; i++) begin
			span(1'b1, n);
			check("ws half", 32'(n), 32'd32);
		end
		span(1'b0, n);
		span(1'b0, n);
		check("bck half", 32'(n), 32'd2);
		wr_reg(`SAR_OFF_CTRL, 32'h0003_1F00);
		repeat (4) @(posedge mclk);
		#1;
		check("slave oe", {30'h0, bck_oe, ws_oe}, 32'h0);
		$display("test master done");
		end_sim();
	end

	initial begin
		#200000;
		fail_count++;
		$display("ERROR watchdog expected done seen timeout");
		end_sim();
	end
endmodule // test_i2s_input_receive_buffer
